//--- design/ofs_pkg.sv
// Purpose: constants for the output fault status register bank
// Assumes: byte-wide command-coded register access
// Notes: flag bit positions shared by design and bench
package ofs_pkg;
  localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7A;
  localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7B;
  localparam int VF_OVF = 7;
  localparam int VF_OVW = 6;
  localparam int VF_UVW = 5;
  localparam int VF_UVF = 4;
  localparam int VF_CLAMP = 3;
  localparam int IF_OCF = 7;
  localparam int IF_OCLV = 6;
  localparam int IF_OCW = 5;
  localparam int IF_UCF = 4;
  localparam logic [7:0] VOUT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] IOUT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] VOUT_W1C_MASK = 8'hF8;
  localparam logic [7:0] IOUT_W1C_MASK = 8'hB0;
  localparam logic [7:0] IOUT_LIVE_MASK = 8'hF0;
  // nonvolatile overcurrent mask default: zero lets the alert through
  localparam logic OC_MASK_NV_DEFAULT = 1'b0;
endpackage : ofs_pkg

//--- design/ofs_status_regs.sv
// Purpose: latched output voltage/current fault status bytes
// Assumes: fault inputs are asynchronous levels from analog detectors
// Notes: single-byte read and write by command code
// Notes on behaviour
// R1: voltage flags byte at its command code
// R2: current flags byte at its command code
// R3: alert mask never gates flag setting
// R4: disable bit blocks matching flag
// R5: flags stay latched after source goes
// R6: clear-all, rail on, reset clear flags
// R7: write one clears bit except current bit 6, zero keeps
// R8: voltage byte bit layout, write-one-clear
// R9: unused low bits read zero
// R10: overvoltage fault after soft start sets warning
// R11: overvoltage fault before soft start, no warning
// R12: undervoltage fault also sets its warning
// R13: setpoint limit violation sets clamp warning
// R14: overcurrent fault latches current bit 7
// R15: overcurrent warning latches current bit 5
// R16: undercurrent fault latches current bit 4
// R17: low voltage with overcurrent latches bit 6
// R18: bit 6 cleared via undervoltage fault clear
// R19: overcurrent masks share one stored bit
// R20: run-time masks written independently
// R21: stored bit tracks warning mask position
// R22: set beats coincident clear
// R23: flags set on synchronised rising edge
`timescale 1ns/1ps
`default_nettype none
module ofs_status_regs
  import ofs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] cmdCode,
  input wire logic wrStrobe,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic clearAll,
  input wire logic railTurnOn,
  input wire logic [4:0] voutEventIn,
  input wire logic [3:0] ioutEventIn,
  input wire logic softStartDone,
  input wire logic [4:0] voutDisable,
  input wire logic [3:0] ioutDisable,
  input wire logic maskWrStrobe,
  input wire logic [1:0] maskWrData,
  input wire logic maskRestore,
  input wire logic nvMaskIn,
  output logic [1:0] ocAlertMask,
  output logic nvMaskOut
);
  // voutEventIn: [4]ovf [3]ovw [2]uvw [1]uvf [0]clamp
  // ioutEventIn: [3]ocf [2]oclv [1]ocw [0]ucf
  logic [8:0] evSync1_ff;
  logic [8:0] evSync2_ff;
  logic [8:0] evLast_ff;
  logic ssSync1_ff;
  logic ssSync2_ff;
  logic [8:0] evRise;
  logic [7:0] voutFlags_ff;
  logic [7:0] nxt_voutFlags;
  logic [7:0] ioutFlags_ff;
  logic [7:0] nxt_ioutFlags;
  logic [7:0] voutSet;
  logic [7:0] ioutSet;
  logic [7:0] voutClr;
  logic [7:0] ioutClr;
  logic [1:0] ocMask_ff;
  logic nvStrapped_ff;
  logic railOnSync1_ff;
  logic railOnSync2_ff;
  logic railOnLast_ff;
  logic railOnRise;

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evSync1_ff <= 9'h000;
      evSync2_ff <= 9'h000;
      evLast_ff <= 9'h000;
      ssSync1_ff <= 1'b0;
      ssSync2_ff <= 1'b0;
    end else begin
      evSync1_ff <= {voutEventIn, ioutEventIn};
      evSync2_ff <= evSync1_ff;
      evLast_ff <= evSync2_ff;
      ssSync1_ff <= softStartDone;
      ssSync2_ff <= ssSync1_ff;
    end
  end

  // rail turn-on may come from the on/off pin, hence synchronised
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      railOnSync1_ff <= 1'b0;
      railOnSync2_ff <= 1'b0;
      railOnLast_ff <= 1'b0;
    end else begin
      railOnSync1_ff <= railTurnOn;
      railOnSync2_ff <= railOnSync1_ff;
      railOnLast_ff <= railOnSync2_ff;
    end
  end
  assign railOnRise = railOnSync2_ff & ~railOnLast_ff;

  // R23: rising edge detect
  assign evRise = evSync2_ff & ~evLast_ff;

  // R3: mask not consulted here
  always_comb begin
    voutSet = 8'h00;
    ioutSet = 8'h00;
    // R4: disables gate sets
    voutSet[VF_OVF] = evRise[8] & ~voutDisable[4];
    // R10: ovf after soft start
    // R11: fixed ovf skips warning
    voutSet[VF_OVW] = (evRise[7] & ~voutDisable[3])
                    | (voutSet[VF_OVF] & ssSync2_ff & ~voutDisable[3]);
    voutSet[VF_UVF] = evRise[5] & ~voutDisable[1];
    // R12: uvf drags warning
    voutSet[VF_UVW] = (evRise[6] & ~voutDisable[2])
                    | (voutSet[VF_UVF] & ~voutDisable[2]);
    // R13: clamp warning
    voutSet[VF_CLAMP] = evRise[4] & ~voutDisable[0];
    // R14: overcurrent fault
    ioutSet[IF_OCF] = evRise[3] & ~ioutDisable[3];
    // R17: low voltage overcurrent
    ioutSet[IF_OCLV] = evRise[2] & ~ioutDisable[2];
    // R15: overcurrent warning
    ioutSet[IF_OCW] = evRise[1] & ~ioutDisable[1];
    // R16: undercurrent fault
    ioutSet[IF_UCF] = evRise[0] & ~ioutDisable[0];
  end

  always_comb begin
    voutClr = 8'h00;
    ioutClr = 8'h00;
    // R7: write-one clears
    if (wrStrobe && cmdCode == CMD_VOUT_FLAGS) begin
      voutClr = wrData & VOUT_W1C_MASK;
      // R18: uvf clear also clears bit 6
      ioutClr[IF_OCLV] = wrData[VF_UVF];
    end
    if (wrStrobe && cmdCode == CMD_IOUT_FLAGS) begin
      ioutClr = ioutClr | (wrData & IOUT_W1C_MASK);
    end
    // R6: clear-all and rail on
    if (clearAll || railOnRise) begin
      voutClr = 8'hFF;
      ioutClr = 8'hFF;
    end
  end

  // R22: set wins over clear
  // R5: hold until cleared
  assign nxt_voutFlags = ((voutFlags_ff & ~voutClr) | voutSet) & VOUT_W1C_MASK;
  assign nxt_ioutFlags = ((ioutFlags_ff & ~ioutClr) | ioutSet) & IOUT_LIVE_MASK;

  // R6: power cycle clears
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      voutFlags_ff <= VOUT_FLAGS_RESET;
      ioutFlags_ff <= IOUT_FLAGS_RESET;
    end else begin
      voutFlags_ff <= nxt_voutFlags;
      ioutFlags_ff <= nxt_ioutFlags;
    end
  end

  // R1: command decode
  // R2: command decode
  // R9: low bits zero by masking
  always_comb begin
    unique case (cmdCode)
      CMD_VOUT_FLAGS: rdData = voutFlags_ff;
      CMD_IOUT_FLAGS: rdData = ioutFlags_ff;
      default: rdData = 8'h00;
    endcase
  end

  // restore waits one edge after reset so the stored bit is sampled, not reset-loaded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nvStrapped_ff <= 1'b0;
    end else begin
      nvStrapped_ff <= 1'b1;
    end
  end

  // maskWrData: [1]ocf mask, [0]ocw mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ocMask_ff <= {OC_MASK_NV_DEFAULT, OC_MASK_NV_DEFAULT};
    // R19: restore sets both alike
    end else if (!nvStrapped_ff || maskRestore) begin
      ocMask_ff <= {nvMaskIn, nvMaskIn};
    // R20: independent run-time writes
    end else if (maskWrStrobe) begin
      ocMask_ff <= maskWrData;
    end
  end
  assign ocAlertMask = ocMask_ff;
  // R21: save from warning position
  assign nvMaskOut = ocMask_ff[0];

  a_vout_clear_wr: assert property (@(posedge clk) disable iff (!reset_n)
    wrStrobe && cmdCode == CMD_VOUT_FLAGS && wrData[VF_OVF] && !voutSet[VF_OVF]
    |=> !voutFlags_ff[VF_OVF]) else $error("overvoltage flag not cleared"); // R7
  a_flag_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    voutFlags_ff[VF_CLAMP] && !wrStrobe && !clearAll && !railOnRise
    |=> voutFlags_ff[VF_CLAMP]) else $error("clamp flag dropped"); // R5
  a_ovw_after_ss: assert property (@(posedge clk) disable iff (!reset_n)
    evRise[8] && !voutDisable[4] && !voutDisable[3] && ssSync2_ff
    |=> voutFlags_ff[VF_OVW]) else $error("warning missing after fault"); // R10
  a_uvf_sets_uvw: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(voutFlags_ff[VF_UVF]) && !voutDisable[2] |-> voutFlags_ff[VF_UVW])
    else $error("undervolt warning missing"); // R12
  a_oclv_no_self: assert property (@(posedge clk) disable iff (!reset_n)
    wrStrobe && cmdCode == CMD_IOUT_FLAGS && !clearAll && !railOnRise
    && ioutFlags_ff[IF_OCLV] |=> ioutFlags_ff[IF_OCLV])
    else $error("bit 6 cleared by direct write"); // R18
  a_low_bits_zero: assert property (@(posedge clk) disable iff (!reset_n)
    voutFlags_ff[2:0] == 3'h0 && ioutFlags_ff[3:0] == 4'h0)
    else $error("reserved bits set"); // R9
  a_disable_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    voutDisable[0] && !voutFlags_ff[VF_CLAMP] |=> !voutFlags_ff[VF_CLAMP])
    else $error("disabled flag set"); // R4
  a_set_beats_clr: assert property (@(posedge clk) disable iff (!reset_n)
    clearAll && ioutSet[IF_OCF] |=> ioutFlags_ff[IF_OCF])
    else $error("event lost on clear"); // R22
  a_clear_all: assert property (@(posedge clk) disable iff (!reset_n)
    clearAll && ioutSet == 8'h00 |=> ioutFlags_ff == 8'h00)
    else $error("clear-all failed"); // R6
  a_restore_equal: assert property (@(posedge clk) disable iff (!reset_n)
    maskRestore |=> ocAlertMask[1] == ocAlertMask[0])
    else $error("masks differ after restore"); // R19

  c_ovf_then_clear: cover property (@(posedge clk) disable iff (!reset_n)
    voutFlags_ff[VF_OVF] ##[1:20] !voutFlags_ff[VF_OVF]);
  c_oclv_cleared: cover property (@(posedge clk) disable iff (!reset_n)
    ioutFlags_ff[IF_OCLV] ##1 !ioutFlags_ff[IF_OCLV]);
  c_masks_differ: cover property (@(posedge clk) disable iff (!reset_n)
    ocAlertMask[1] != ocAlertMask[0]);
  c_set_meets_clear: cover property (@(posedge clk) disable iff (!reset_n)
    clearAll && (ioutSet != 8'h00));
  c_restore_ones: cover property (@(posedge clk) disable iff (!reset_n)
    maskRestore && nvMaskIn);

  // R1: voltage byte readback
  a_vout_rd_map: assert property (@(posedge clk) disable iff (!reset_n) // R1
    cmdCode == CMD_VOUT_FLAGS
    |-> rdData == voutFlags_ff)
    else $error("voltage byte readback wrong");
  // R2: current byte readback
  a_iout_rd_map: assert property (@(posedge clk) disable iff (!reset_n) // R2
    cmdCode == CMD_IOUT_FLAGS
    |-> rdData == ioutFlags_ff)
    else $error("current byte readback wrong");
  // R1: foreign codes read zero
  a_other_rd_zero: assert property (@(posedge clk) disable iff (!reset_n) // R1
    cmdCode != CMD_VOUT_FLAGS && cmdCode != CMD_IOUT_FLAGS
    |-> rdData == 8'h00)
    else $error("foreign code returned data");
  // R9: voltage low bits zero
  a_rd_vout_low: assert property (@(posedge clk) disable iff (!reset_n) // R9
    cmdCode == CMD_VOUT_FLAGS
    |-> rdData[2:0] == 3'h0)
    else $error("voltage low bits not zero");
  // R9: current low bits zero
  a_rd_iout_low: assert property (@(posedge clk) disable iff (!reset_n) // R9
    cmdCode == CMD_IOUT_FLAGS
    |-> rdData[3:0] == 4'h0)
    else $error("current low bits not zero");
  // R23: overvoltage fault sets
  a_ovf_sets: assert property (@(posedge clk) disable iff (!reset_n) // R23
    evRise[8] && !voutDisable[4]
    |=> voutFlags_ff[VF_OVF])
    else $error("overvoltage fault flag missing");
  // R12: undervolt fault pair
  a_uvf_pair: assert property (@(posedge clk) disable iff (!reset_n) // R12
    evRise[5] && !voutDisable[1] && !voutDisable[2]
    |=> voutFlags_ff[VF_UVF] && voutFlags_ff[VF_UVW])
    else $error("undervolt fault pair missing");
  // R11: early fault, no warning
  a_ovf_pre_ss: assert property (@(posedge clk) disable iff (!reset_n) // R11
    evRise[8] && !evRise[7] && !ssSync2_ff && !voutFlags_ff[VF_OVW]
    |=> !voutFlags_ff[VF_OVW])
    else $error("warning set before soft start");
  // R13: clamp warning sets
  a_clamp_sets: assert property (@(posedge clk) disable iff (!reset_n) // R13
    evRise[4] && !voutDisable[0]
    |=> voutFlags_ff[VF_CLAMP])
    else $error("clamp warning missing");
  // R14: overcurrent fault sets
  a_ocf_sets: assert property (@(posedge clk) disable iff (!reset_n) // R14
    evRise[3] && !ioutDisable[3]
    |=> ioutFlags_ff[IF_OCF])
    else $error("overcurrent fault flag missing");
  // R15: overcurrent warning sets
  a_ocw_sets: assert property (@(posedge clk) disable iff (!reset_n) // R15
    evRise[1] && !ioutDisable[1]
    |=> ioutFlags_ff[IF_OCW])
    else $error("overcurrent warning flag missing");
  // R16: undercurrent fault sets
  a_ucf_sets: assert property (@(posedge clk) disable iff (!reset_n) // R16
    evRise[0] && !ioutDisable[0]
    |=> ioutFlags_ff[IF_UCF])
    else $error("undercurrent flag missing");
  // R17: low voltage overcurrent sets
  a_oclv_sets: assert property (@(posedge clk) disable iff (!reset_n) // R17
    evRise[2] && !ioutDisable[2]
    |=> ioutFlags_ff[IF_OCLV])
    else $error("bit 6 flag missing");
  // R18: cleared via voltage byte
  a_oclv_uvf_clr: assert property (@(posedge clk) disable iff (!reset_n) // R18
    wrStrobe && cmdCode == CMD_VOUT_FLAGS && wrData[VF_UVF] && !ioutSet[IF_OCLV]
    |=> !ioutFlags_ff[IF_OCLV])
    else $error("bit 6 not cleared by undervolt clear");
  // R7: zero write keeps flag
  a_write_zero_keep: assert property (@(posedge clk) disable iff (!reset_n) // R7
    wrStrobe && cmdCode == CMD_VOUT_FLAGS && !wrData[VF_OVF] && !clearAll
    && !railOnRise && voutFlags_ff[VF_OVF] |=> voutFlags_ff[VF_OVF])
    else $error("zero write cleared a flag");
  // R6: rail on clears
  a_rail_on_clear: assert property (@(posedge clk) disable iff (!reset_n) // R6
    railOnRise && voutSet == 8'h00
    |=> voutFlags_ff == 8'h00)
    else $error("rail turn-on did not clear");
  // R4: disabled warning blocked
  a_ocw_disable: assert property (@(posedge clk) disable iff (!reset_n) // R4
    ioutDisable[1] && !ioutFlags_ff[IF_OCW]
    |=> !ioutFlags_ff[IF_OCW])
    else $error("disabled warning set");
  // R5: overcurrent fault holds
  a_ocf_hold: assert property (@(posedge clk) disable iff (!reset_n) // R5
    ioutFlags_ff[IF_OCF] && !wrStrobe && !clearAll && !railOnRise
    |=> ioutFlags_ff[IF_OCF])
    else $error("overcurrent flag dropped");
  // R20: run-time mask write
  a_mask_write: assert property (@(posedge clk) disable iff (!reset_n) // R20
    maskWrStrobe && !maskRestore && nvStrapped_ff
    |=> ocAlertMask == $past(maskWrData))
    else $error("mask write lost");
  // R21: restore from stored bit
  a_restore_value: assert property (@(posedge clk) disable iff (!reset_n) // R21
    maskRestore
    |=> nvMaskOut == $past(nvMaskIn))
    else $error("stored bit not restored");
  // R23: held level sets once
  a_level_once: assert property (@(posedge clk) disable iff (!reset_n) // R23
    evSync2_ff[4] && evLast_ff[4]
    |-> !voutSet[VF_CLAMP])
    else $error("held level set again");
endmodule : ofs_status_regs
`default_nettype wire

//--- tb/ofs_host_model.sv
// Purpose: host side of the output flag register bank
// Assumes: single-byte reads and writes by command code
// Notes: drives on falling edge, one request at a time
`timescale 1ns/1ps
`default_nettype none
module ofs_host_model (
  input wire logic clk,
  output logic [7:0] cmdCode,
  output logic wrStrobe,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  initial begin
    cmdCode = 8'h00;
    wrStrobe = 1'b0;
    wrData = 8'h00;
  end
  task automatic wrByte(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    cmdCode = c;
    wrData = d;
    wrStrobe = 1'b1;
    @(negedge clk);
    wrStrobe = 1'b0;
    // stale data inverted so a late capture shows
    wrData = ~d;
  endtask : wrByte
  task automatic rdByte(input logic [7:0] c, output logic [7:0] d);
    @(negedge clk);
    cmdCode = c;
    @(negedge clk);
    d = rdData;
  endtask : rdByte
endmodule : ofs_host_model
`default_nettype wire

//--- tb/tb_output_fault_status_regs.sv
// Purpose: self-checking bench for the output flag registers
// Assumes: host model drives the byte bus
// Notes: integer flag model, random single events
`timescale 1ns/1ps
`default_nettype none
module tb_output_fault_status_regs;
  import ofs_pkg::*;
  logic clk, reset_n, clearAll, railTurnOn, softStartDone, maskWrStrobe, maskRestore, nvMaskIn;
  logic wrStrobe, nvMaskOut;
  logic [7:0] cmdCode, wrData, rdData, rd;
  logic [4:0] voutEventIn, voutDisable;
  logic [3:0] ioutEventIn, ioutDisable;
  logic [1:0] maskWrData, ocAlertMask;
  logic [31:0] r;
  int errors, comparisons, expV, expI, idx, dis;
  int seed = 32'h7c47eaa1;
  ofs_status_regs dut_u (.clk, .reset_n, .cmdCode, .wrStrobe, .wrData, .rdData, .clearAll,
    .railTurnOn, .voutEventIn, .ioutEventIn, .softStartDone, .voutDisable, .ioutDisable,
    .maskWrStrobe, .maskWrData, .maskRestore, .nvMaskIn, .ocAlertMask, .nvMaskOut);
  ofs_host_model host_u (.clk, .cmdCode, .wrStrobe, .wrData, .rdData);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdChk();
    host_u.rdByte(CMD_VOUT_FLAGS, rd);
    chk(rd, 8'(expV));
    host_u.rdByte(CMD_IOUT_FLAGS, rd);
    chk(rd, 8'(expI));
  endtask : rdChk
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic events(input int n);
    for (int k = 0; k < n; k++) begin
      r = $random(seed);
      softStartDone = r[2];
      idx = r[7:4] % 9;
      // cross-linked faults are never disabled, their coupling is open
      dis = r[3] && idx != 4 && idx != 1;
      @(negedge clk);
      maskWrData = r[1:0];
      maskWrStrobe = 1'b1;
      if (idx < 5) begin
        voutDisable = 5'(dis) << idx;
        voutEventIn = 5'h01 << idx;
      end else begin
        ioutDisable = 4'(dis) << (idx - 5);
        ioutEventIn = 4'h1 << (idx - 5);
      end
      @(negedge clk);
      maskWrStrobe = 1'b0;
      chk({6'h00, ocAlertMask}, {6'h00, r[1:0]});
      repeat (3) @(negedge clk);
      voutEventIn = 5'h00;
      ioutEventIn = 4'h0;
      repeat (3) @(negedge clk);
      voutDisable = 5'h00;
      ioutDisable = 4'h0;
      if (!dis && idx < 5) expV |= (1 << (idx + 3)) | ((idx == 4 && r[2]) ? 8'h40 : 8'h00);
      if (!dis && idx == 1) expV |= 8'h20;
      if (!dis && idx >= 5) expI |= 1 << (idx - 1);
      rdChk();
      if (k % 2 == 1) begin
        host_u.wrByte(CMD_VOUT_FLAGS, r[15:8]);
        expV &= ~(r[15:8] & VOUT_W1C_MASK);
        if (r[12]) expI &= ~8'h40;
        host_u.wrByte(CMD_IOUT_FLAGS, r[23:16]);
        expI &= ~(r[23:16] & IOUT_W1C_MASK);
      end
    end
  endtask : events
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1ms;
    errors++;
    conclude();
  end
  initial begin
    {reset_n, clearAll, railTurnOn, softStartDone, maskWrStrobe, maskRestore, nvMaskIn} = 7'h00;
    {voutEventIn, voutDisable, ioutEventIn, ioutDisable, maskWrData} = 20'h00000;
    expV = 0;
    expI = 0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h00, ocAlertMask}, 8'h00);
    rdChk();
    host_u.rdByte(8'h7C, rd);
    chk(rd, 8'h00);
    events(40);
    $display("test events done");
    @(negedge clk);
    clearAll = 1'b1;
    @(negedge clk);
    clearAll = 1'b0;
    {expV, expI} = 0;
    rdChk();
    events(20);
    railTurnOn = 1'b1;
    repeat (4) @(negedge clk);
    {expV, expI} = 0;
    rdChk();
    railTurnOn = 1'b0;
    $display("test clear-all and rail-on done");
    events(20);
    nvMaskIn = 1'b1;
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    {expV, expI} = 0;
    chk({5'h00, nvMaskOut, ocAlertMask}, 8'h07);
    rdChk();
    maskWrData = 2'b10;
    maskWrStrobe = 1'b1;
    @(negedge clk);
    maskWrStrobe = 1'b0;
    chk({7'h00, nvMaskOut}, 8'h00);
    $display("test power cycle and masks done");
    ioutEventIn = 4'h8;
    repeat (2) @(negedge clk);
    clearAll = 1'b1;
    @(negedge clk);
    clearAll = 1'b0;
    ioutEventIn = 4'h0;
    expI = 8'h80;
    rdChk();
    nvMaskIn = 1'b0;
    maskRestore = 1'b1;
    @(negedge clk);
    maskRestore = 1'b0;
    chk({5'h00, nvMaskOut, ocAlertMask}, 8'h00);
    $display("test coincident clear and restore done");
    conclude();
  end
endmodule : tb_output_fault_status_regs
`default_nettype wire
